//--- hw/rapc_pkg.sv
// Constants for the repeater accessory port control block.
// Assumes a single 25 MHz clock and an AXI4-Lite register bus.
package rapc_pkg;
	// Register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_PINS = 8'h04;
	localparam logic [7:0] ADDR_STAT = 8'h08;
	// Control register fields
	localparam int CTRL_UNFILT   = 0;
	localparam int CTRL_DEEMPH   = 1;
	localparam int CTRL_PREEMPH  = 2;
	localparam int CTRL_PRIO_LSB = 3;
	localparam int CTRL_RPTDIS   = 5;
	localparam int CTRL_MODE_LSB = 6;
	localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
	localparam logic [31:0] CTRL_MASK = 32'h0000_00FF;
	// Pin configuration fields
	localparam int NUM_IN       = 4;
	localparam int NUM_OUT      = 3;
	localparam int PIN_IPOL_LSB = 0;
	localparam int PIN_OPOL_LSB = 4;
	localparam int PIN_KTT_LSB  = 8;
	localparam int PIN_MON_LSB  = 10;
	localparam int PIN_KD_LSB   = 12;
	localparam logic [31:0] PINS_RST  = 32'h0000_2400;
	localparam logic [31:0] PINS_MASK = 32'h0000_3F7F;
	// Output pin positions
	localparam int OUT_SQ   = 0;
	localparam int OUT_TONE = 1;
	localparam int OUT_ANT  = 2;
	// Status fields
	localparam int STAT_GRANT_LSB = 0;
	localparam int STAT_TXKEY     = 2;
	localparam int STAT_BUSY      = 3;
	localparam int STAT_UNMUTE    = 4;
	localparam int STAT_PINS_LSB  = 8;
	localparam int STAT_OUTS_LSB  = 12;
	// Field codes
	localparam logic [1:0] PRIO_NONE  = 2'h0;
	localparam logic [1:0] PRIO_EXT   = 2'h1;
	localparam logic [1:0] PRIO_RPT   = 2'h2;
	localparam logic [1:0] MODE_ANA   = 2'h0;
	localparam logic [1:0] MODE_DIG   = 2'h1;
	localparam logic [1:0] MODE_MIXED = 2'h2;
	localparam logic [1:0] GRANT_IDLE = 2'h0;
	localparam logic [1:0] GRANT_EXT  = 2'h1;
	localparam logic [1:0] GRANT_RPT  = 2'h2;
	localparam logic [1:0] GRANT_DIG  = 2'h3;
	localparam logic [1:0] RESP_OKAY  = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {ARB_IDLE, ARB_EXT, ARB_RPT, ARB_DIG} rapc_arb_t;
endpackage

//--- hw/rapc_top.sv
// Transmitter arbitration, audio path selection and programmable pins
// for a repeater rear accessory port, with an AXI4-Lite register slave.
// Assumes all inputs synchronous to mclk except acc_in, which is resynced.
//
// Notes on behaviour
// - Band-limited type passes only 300 Hz to 3 kHz to rx output and tx.
// - Unfiltered type routes audio without filtering to tx, rx output, speaker.
// - Separate enables for rx de-emphasis and tx pre-emphasis.
// - Unfiltered type forces all accessory emphasis off.
// - With repeat path enabled, priority setting picks key-to-talk or repeat.
// - Priority none grants the transmitter first come, first served.
// - Mixed mode arbitrates digital transmissions first come, ignoring priority.
// - Repeat-path disable keys transmitter only on external key-to-talk in analog mode.
// - Mixed mode still repeats over-air digital traffic despite repeat disable.
// - Each programmable pin has polarity; key-to-talk assignable to any pin.
// - Mixed mode: key-to-talk on busy channel raises busy alert tone.
// - Squelch-detect output follows squelch detection.
// - Tone-code-detect output follows qualifying tone-code reception.
// - Mixed mode: detect outputs also active on digital call or station id.
// - Mixed mode: detect outputs drop only when all their conditions are false.
// - Monitor forces carrier squelch; RF signal enables rx audio and speaker.
// - Mixed mode monitor: digital activity gives busy tone, stays muted.
// - Knockdown acts as repeat disable, tx audio from tx audio input.
// - Knockdown release returns to normal; qualified RF may key again.
// - Mixed mode ignores knockdown during a digital transmission.
// - Antenna relay active in transmit, inactive in idle or receive.
// - Antenna relay disabled in digital and mixed modes.
`timescale 1ns/1ps
module rapc_top
(
	input  wire logic                          mclk,          // 25 MHz clock
	input  wire logic                          rst,           // Sync reset, high
	input  wire logic [7:0]                    s_axi_awaddr,  // Write address
	input  wire logic                          s_axi_awvalid, // Write address valid
	output logic                               s_axi_awready, // Write address ready
	input  wire logic [31:0]                   s_axi_wdata,   // Write data
	input  wire logic [3:0]                    s_axi_wstrb,   // Write strobes
	input  wire logic                          s_axi_wvalid,  // Write data valid
	output logic                               s_axi_wready,  // Write data ready
	output logic [1:0]                         s_axi_bresp,   // Write response
	output logic                               s_axi_bvalid,  // Write response valid
	input  wire logic                          s_axi_bready,  // Write response ready
	input  wire logic [7:0]                    s_axi_araddr,  // Read address
	input  wire logic                          s_axi_arvalid, // Read address valid
	output logic                               s_axi_arready, // Read address ready
	output logic [31:0]                        s_axi_rdata,   // Read data
	output logic [1:0]                         s_axi_rresp,   // Read response
	output logic                               s_axi_rvalid,  // Read data valid
	input  wire logic                          s_axi_rready,  // Read data ready
	input  wire logic [rapc_pkg::NUM_IN-1:0]   acc_in,        // Programmable input pins
	output logic [rapc_pkg::NUM_OUT-1:0]       acc_out,       // Programmable output pins
	input  wire logic                          squelch_det,   // Squelch detected
	input  wire logic                          tone_det,      // Tone-code rules met
	input  wire logic                          rf_carrier,    // RF carrier present
	input  wire logic                          repeat_req,    // Qualified RF wants repeat
	input  wire logic                          dig_rx_req,    // Digital over-air to repeat
	input  wire logic                          dig_tx_active, // Digital call incl hang
	input  wire logic                          station_identification, // Id transmitting
	input  wire logic                          chan_busy,     // Channel busy
	input  wire logic                          dig_activity,  // Digital channel activity
	output logic                               tx_key,        // Key transmitter
	output logic                               tx_from_input, // Tx audio from input pin
	output logic                               band_filt_en,  // 300 Hz-3 kHz filter on
	output logic                               rx_deemph,     // Rx de-emphasis on
	output logic                               tx_preemph,    // Tx pre-emphasis on
	output logic                               carrier_sq,    // Carrier squelch mode
	output logic                               rx_audio_en,   // Rx audio lines on
	output logic                               spkr_unmute,   // Speaker unmuted
	output logic                               busy_tone      // Busy alert tone
);
	logic [31:0]                    ctrl_q;
	logic [31:0]                    pins_q;
	logic [rapc_pkg::NUM_IN-1:0]    sync1_q;
	logic [rapc_pkg::NUM_IN-1:0]    sync2_q;
	logic [rapc_pkg::NUM_IN-1:0]    pin_on;
	rapc_pkg::rapc_arb_t            arb_q;
	rapc_pkg::rapc_arb_t            arb_d;
	logic                           aw_got_q;
	logic                           w_got_q;
	logic [7:0]                     waddr_q;
	logic [31:0]                    wdata_q;
	logic [3:0]                     wstrb_q;
	logic [31:0]                    wmask;
	logic [1:0]                     grant_code;
	logic [31:0]                    stat_word;
	logic                           unfilt;
	logic                           mixed;
	logic [1:0]                     prio;
	logic [1:0]                     mode;
	logic                           ktt_on;
	logic                           mon_on;
	logic                           kd_on;
	logic                           kd_eff;
	logic                           rpt_block;
	logic                           rpt_ok;
	logic                           dig_req;
	logic                           dig_ok;
	logic                           ana_ok;
	logic [rapc_pkg::NUM_OUT-1:0]   out_val;
	logic [rapc_pkg::NUM_OUT-1:0]   opol;

	assign unfilt = ctrl_q[rapc_pkg::CTRL_UNFILT];
	assign prio   = ctrl_q[rapc_pkg::CTRL_PRIO_LSB +: 2];
	assign mode   = ctrl_q[rapc_pkg::CTRL_MODE_LSB +: 2];
	assign mixed  = (mode == rapc_pkg::MODE_MIXED);
	assign ana_ok = (mode != rapc_pkg::MODE_DIG);
	assign dig_ok = (mode != rapc_pkg::MODE_ANA);
	assign opol   = pins_q[rapc_pkg::PIN_OPOL_LSB +: rapc_pkg::NUM_OUT];

	// Input resynchronisation
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			sync1_q <= '0;
			sync2_q <= '0;
		end
		else
		begin
			sync1_q <= acc_in;
			sync2_q <= sync1_q;
		end
	end

	// Polarity and function mapping of input pins
	assign pin_on = sync2_q ^ pins_q[rapc_pkg::PIN_IPOL_LSB +: rapc_pkg::NUM_IN];
	assign ktt_on = pin_on[pins_q[rapc_pkg::PIN_KTT_LSB +: 2]];
	assign mon_on = pin_on[pins_q[rapc_pkg::PIN_MON_LSB +: 2]];
	assign kd_on  = pin_on[pins_q[rapc_pkg::PIN_KD_LSB +: 2]];

	// Knockdown is a temporary repeat disable, ignored during digital tx in mixed mode
	assign kd_eff    = kd_on && !(mixed && dig_tx_active);
	assign rpt_block = ctrl_q[rapc_pkg::CTRL_RPTDIS] || kd_eff;
	assign rpt_ok    = ana_ok && repeat_req && !rpt_block;
	assign dig_req   = dig_ok && dig_rx_req;

	// Transmitter arbitration; ties resolved at idle only
	always_comb
	begin
		arb_d = arb_q;
		case (arb_q)
			rapc_pkg::ARB_IDLE:
			begin
				if (dig_req)
					arb_d = rapc_pkg::ARB_DIG;
				else if (ktt_on && rpt_ok)
					arb_d = (prio == rapc_pkg::PRIO_RPT) ? rapc_pkg::ARB_RPT
						: rapc_pkg::ARB_EXT;
				else if (ktt_on)
					arb_d = rapc_pkg::ARB_EXT;
				else if (rpt_ok)
					arb_d = rapc_pkg::ARB_RPT;
			end
			rapc_pkg::ARB_EXT:
				if (!ktt_on)
					arb_d = rapc_pkg::ARB_IDLE;
			rapc_pkg::ARB_RPT:
				if (!rpt_ok)
					arb_d = rapc_pkg::ARB_IDLE;
			rapc_pkg::ARB_DIG:
				if (!dig_req)
					arb_d = rapc_pkg::ARB_IDLE;
			default:
				arb_d = rapc_pkg::ARB_IDLE;
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			arb_q <= rapc_pkg::ARB_IDLE;
		else
			arb_q <= arb_d;
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			tx_key        <= 1'b0;
			tx_from_input <= 1'b0;
		end
		else
		begin
			tx_key        <= (arb_d != rapc_pkg::ARB_IDLE);
			tx_from_input <= (arb_d == rapc_pkg::ARB_EXT) || rpt_block;
		end
	end

	// Audio path selection
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			band_filt_en <= 1'b0;
			rx_deemph    <= 1'b0;
			tx_preemph   <= 1'b0;
		end
		else
		begin
			band_filt_en <= !unfilt;
			rx_deemph    <= !unfilt && ctrl_q[rapc_pkg::CTRL_DEEMPH];
			tx_preemph   <= !unfilt && ctrl_q[rapc_pkg::CTRL_PREEMPH];
		end
	end

	// Monitor, unmute and busy tone
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			carrier_sq  <= 1'b0;
			rx_audio_en <= 1'b0;
			spkr_unmute <= 1'b0;
			busy_tone   <= 1'b0;
		end
		else
		begin
			carrier_sq <= mon_on;
			if (mon_on)
			begin
				rx_audio_en <= rf_carrier && !(mixed && dig_activity);
				spkr_unmute <= rf_carrier && !(mixed && dig_activity);
			end
			else
			begin
				rx_audio_en <= squelch_det;
				spkr_unmute <= squelch_det;
			end
			busy_tone <= mixed && ((ktt_on && chan_busy) || (mon_on && dig_activity));
		end
	end

	// Detect and relay outputs with polarity
	always_comb
	begin
		out_val = '0;
		out_val[rapc_pkg::OUT_SQ]   = squelch_det
			|| (mixed && (dig_tx_active || station_identification));
		out_val[rapc_pkg::OUT_TONE] = tone_det
			|| (mixed && (dig_tx_active || station_identification));
		out_val[rapc_pkg::OUT_ANT]  = (mode == rapc_pkg::MODE_ANA)
			&& (arb_d != rapc_pkg::ARB_IDLE);
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			acc_out <= '0;
		else
			acc_out <= out_val ^ opol;
	end

	// AXI4-Lite write channel
	always_comb
	begin
		wmask = '0;
		for (int i = 0; i < 4; i++)
			wmask[i*8 +: 8] = {8{wstrb_q[i]}};
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			s_axi_awready <= 1'b0;
			aw_got_q      <= 1'b0;
			waddr_q       <= '0;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			s_axi_awready <= 1'b0;
			aw_got_q      <= 1'b1;
			waddr_q       <= s_axi_awaddr;
		end
		else if (s_axi_bvalid && s_axi_bready)
			aw_got_q <= 1'b0;
		else if (!aw_got_q && !s_axi_bvalid)
			s_axi_awready <= 1'b1;
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			s_axi_wready <= 1'b0;
			w_got_q      <= 1'b0;
			wdata_q      <= '0;
			wstrb_q      <= '0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			s_axi_wready <= 1'b0;
			w_got_q      <= 1'b1;
			wdata_q      <= s_axi_wdata;
			wstrb_q      <= s_axi_wstrb;
		end
		else if (s_axi_bvalid && s_axi_bready)
			w_got_q <= 1'b0;
		else if (!w_got_q && !s_axi_bvalid)
			s_axi_wready <= 1'b1;
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= rapc_pkg::RESP_OKAY;
		end
		else if (s_axi_bvalid && s_axi_bready)
			s_axi_bvalid <= 1'b0;
		else if (aw_got_q && w_got_q && !s_axi_bvalid)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (waddr_q[7:2] == rapc_pkg::ADDR_CTRL[7:2]
				|| waddr_q[7:2] == rapc_pkg::ADDR_PINS[7:2]
				|| waddr_q[7:2] == rapc_pkg::ADDR_STAT[7:2])
				? rapc_pkg::RESP_OKAY : rapc_pkg::RESP_SLVERR;
		end
	end

	// Configuration registers
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			ctrl_q <= rapc_pkg::CTRL_RST;
			pins_q <= rapc_pkg::PINS_RST;
		end
		else if (aw_got_q && w_got_q && !s_axi_bvalid)
		begin
			if (waddr_q[7:2] == rapc_pkg::ADDR_CTRL[7:2])
				ctrl_q <= ((ctrl_q & ~wmask) | (wdata_q & wmask)) & rapc_pkg::CTRL_MASK;
			if (waddr_q[7:2] == rapc_pkg::ADDR_PINS[7:2])
				pins_q <= ((pins_q & ~wmask) | (wdata_q & wmask)) & rapc_pkg::PINS_MASK;
		end
	end

	// AXI4-Lite read channel
	always_comb
	begin
		case (arb_q)
			rapc_pkg::ARB_EXT: grant_code = rapc_pkg::GRANT_EXT;
			rapc_pkg::ARB_RPT: grant_code = rapc_pkg::GRANT_RPT;
			rapc_pkg::ARB_DIG: grant_code = rapc_pkg::GRANT_DIG;
			default:           grant_code = rapc_pkg::GRANT_IDLE;
		endcase
		stat_word = '0;
		stat_word[rapc_pkg::STAT_GRANT_LSB +: 2]             = grant_code;
		stat_word[rapc_pkg::STAT_TXKEY]                      = tx_key;
		stat_word[rapc_pkg::STAT_BUSY]                       = busy_tone;
		stat_word[rapc_pkg::STAT_UNMUTE]                     = spkr_unmute;
		stat_word[rapc_pkg::STAT_PINS_LSB +: rapc_pkg::NUM_IN] = sync2_q;
		stat_word[rapc_pkg::STAT_OUTS_LSB +: rapc_pkg::NUM_OUT] = acc_out;
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= rapc_pkg::RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= rapc_pkg::RESP_OKAY;
			case (s_axi_araddr[7:2])
				rapc_pkg::ADDR_CTRL[7:2]: s_axi_rdata <= ctrl_q;
				rapc_pkg::ADDR_PINS[7:2]: s_axi_rdata <= pins_q;
				rapc_pkg::ADDR_STAT[7:2]: s_axi_rdata <= stat_word;
				default:
				begin
					s_axi_rdata <= '0;
					s_axi_rresp <= rapc_pkg::RESP_SLVERR;
				end
			endcase
		end
		else if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
		else if (!s_axi_rvalid)
			s_axi_arready <= 1'b1;
	end

	// Checks
	sequence s_mixed_dig_tx;
		mixed && (dig_tx_active || station_identification);
	endsequence

	sequence s_flat_held;
		unfilt ##1 unfilt;
	endsequence

	a_flat_no_emph: assert property (@(posedge mclk) disable iff (rst)
		s_flat_held |=> !rx_deemph && !tx_preemph && !band_filt_en)
		else $error("emphasis or filter active on unfiltered audio");

	a_rpt_block_drop: assert property (@(posedge mclk) disable iff (rst)
		rpt_block |=> arb_q != rapc_pkg::ARB_RPT)
		else $error("repeat grant held while repeat path blocked");

	a_grant_hold: assert property (@(posedge mclk) disable iff (rst)
		(arb_q == rapc_pkg::ARB_EXT && ktt_on) |=> arb_q == rapc_pkg::ARB_EXT)
		else $error("key-to-talk grant pre-empted");

	a_prio_ext_wins: assert property (@(posedge mclk) disable iff (rst)
		(arb_q == rapc_pkg::ARB_IDLE && ktt_on && rpt_ok && !dig_req
		&& prio == rapc_pkg::PRIO_EXT) |=> tx_key && arb_q == rapc_pkg::ARB_EXT)
		else $error("priority to key-to-talk not honoured");

	a_detect_mixed: assert property (@(posedge mclk) disable iff (rst)
		s_mixed_dig_tx ##0 $stable(opol) |=>
		acc_out[rapc_pkg::OUT_SQ] != opol[rapc_pkg::OUT_SQ]
		&& acc_out[rapc_pkg::OUT_TONE] != opol[rapc_pkg::OUT_TONE])
		else $error("detect outputs inactive during digital transmission");

	a_ant_not_dig: assert property (@(posedge mclk) disable iff (rst)
		(mode != rapc_pkg::MODE_ANA && $stable(opol))
		|=> acc_out[rapc_pkg::OUT_ANT] == opol[rapc_pkg::OUT_ANT])
		else $error("antenna relay active outside analog mode");

	a_busy_ktt: assert property (@(posedge mclk) disable iff (rst)
		(mixed && ktt_on && chan_busy) |=> busy_tone)
		else $error("busy tone missing on key-to-talk into busy channel");

	a_mon_dig_mute: assert property (@(posedge mclk) disable iff (rst)
		(mixed && mon_on && dig_activity) |=> !spkr_unmute && busy_tone)
		else $error("digital activity unmuted while monitoring");

	a_sync_delay: assert property (@(posedge mclk) disable iff (rst)
		1'b1 ##2 1'b1 |-> sync2_q == $past(acc_in, 2))
		else $error("input synchroniser is not two stages");

	a_write_resp: assert property (@(posedge mclk) disable iff (rst)
		(aw_got_q && w_got_q && !s_axi_bvalid) |=> s_axi_bvalid [*1])
		else $error("write response late");
endmodule

//--- verification/rapc_acc_model.sv
// Behavioural accessory on the rear port: drives the programmable inputs
// and decodes the programmable outputs. Assumes the bench sets pin map and polarity.
`timescale 1ns/1ps
module rapc_acc_model
(
	input  wire logic [1:0] ktt_pin,  // Key-to-talk pin number
	input  wire logic [1:0] mon_pin,  // Monitor pin number
	input  wire logic [1:0] kd_pin,   // Knockdown pin number
	input  wire logic [3:0] in_pol,   // Input polarity, 1 = active low
	input  wire logic [2:0] out_pol,  // Output polarity, 1 = active low
	input  wire logic       ktt,      // Request key-to-talk
	input  wire logic       mon,      // Request monitor
	input  wire logic       kd,       // Request knockdown
	input  wire logic [2:0] acc_out,  // Raw output pins
	output logic      [3:0] acc_in,   // Raw input pins
	output logic      [2:0] seen      // Decoded active outputs
);
	// Unused pins rest at their inactive level
	always_comb
	begin
		acc_in = in_pol;
		if (kd)
			acc_in[kd_pin] = ~in_pol[kd_pin];
		if (mon)
			acc_in[mon_pin] = ~in_pol[mon_pin];
		if (ktt)
			acc_in[ktt_pin] = ~in_pol[ktt_pin];
	end
	assign seen = acc_out ^ out_pol;
endmodule

//--- verification/tb_top.sv
// Self-checking bench for the accessory port control block.
// Assumes the accessory model in rapc_acc_model and an AXI4-Lite master here.
`timescale 1ns/1ps
module tb_top;
	logic mclk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic s_axi_rready, ktt, mon, kd, squelch_det, tone_det, rf_carrier, repeat_req;
	logic dig_rx_req, dig_tx_active, station_identification, chan_busy, dig_activity;
	logic tx_key, tx_from_input, band_filt_en, rx_deemph, tx_preemph, carrier_sq;
	logic rx_audio_en, spkr_unmute, busy_tone;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb, acc_in, in_pol;
	logic [1:0] s_axi_bresp, s_axi_rresp, ktt_pin, mon_pin, kd_pin;
	logic [2:0] acc_out, seen, out_pol;
	int n_mismatch, samples_checked;
	logic [1:0] pl [3];
	logic [1:0] gl [3];

	rapc_top i_rapc_top (.mclk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .acc_in, .acc_out,
		.squelch_det, .tone_det, .rf_carrier, .repeat_req, .dig_rx_req, .dig_tx_active,
		.station_identification, .chan_busy, .dig_activity, .tx_key, .tx_from_input,
		.band_filt_en, .rx_deemph, .tx_preemph, .carrier_sq, .rx_audio_en, .spkr_unmute,
		.busy_tone);
	rapc_acc_model i_rapc_acc_model (.ktt_pin, .mon_pin, .kd_pin, .in_pol, .out_pol,
		.ktt, .mon, .kd, .acc_out, .acc_in, .seen);

	initial
	begin
		mclk = 0;
		forever #20 mclk = ~mclk;
	end

	task automatic end_sim;
		$display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk1(input logic g, input logic e, input string m);
		samples_checked++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("ERROR t=%0t %s got %b exp %b", $time, m, g, e);
		end
	endtask

	task automatic chk32(input logic [31:0] g, input logic [31:0] e, input string m);
		samples_checked++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("ERROR t=%0t %s got %h exp %h", $time, m, g, e);
		end
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge mclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw;
		logic w;
		int t;
		aw = 0;
		w = 0;
		t = 0;
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw && w) && t++ < 100)
		begin
			@(posedge mclk);
			if (s_axi_awvalid && s_axi_awready === 1'b1)
			begin
				aw = 1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready === 1'b1)
			begin
				w = 1;
				s_axi_wvalid <= 1'b0;
			end
		end
		while (s_axi_bvalid !== 1'b1 && t++ < 100)
			@(posedge mclk);
		s_axi_bready <= 1'b0;
		chk1(t < 100, 1'b1, "write timeout");
		chk32({30'h0, s_axi_bresp}, {30'h0, er}, "bresp");
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
		input logic [1:0] er);
		int t;
		t = 0;
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
			@(posedge mclk);
		while (s_axi_arready !== 1'b1 && t++ < 100);
		s_axi_arvalid <= 1'b0;
		while (s_axi_rvalid !== 1'b1 && t++ < 100)
			@(posedge mclk);
		s_axi_rready <= 1'b0;
		chk1(t < 100, 1'b1, "read timeout");
		chk32(s_axi_rdata & m, e, "rdata");
		chk32({30'h0, s_axi_rresp}, {30'h0, er}, "rresp");
	endtask

	task automatic gr(input logic [1:0] g);
		rd(rapc_pkg::ADDR_STAT, 32'h0000_0003, {30'h0, g}, rapc_pkg::RESP_OKAY);
	endtask

	function automatic logic [31:0] cw(input logic u, de, pe, rd, input logic [1:0] pr, md);
		return {24'h0, md, rd, pr, pe, de, u};
	endfunction

	initial
	begin
		repeat (20000) @(posedge mclk);
		n_mismatch++;
		end_sim();
	end

	initial
	begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{ktt, mon, kd, squelch_det, tone_det, rf_carrier, repeat_req, dig_rx_req} = '0;
		{dig_tx_active, station_identification, chan_busy, dig_activity} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		{ktt_pin, mon_pin, kd_pin, in_pol, out_pol} = {2'h0, 2'h1, 2'h2, 4'h0, 3'h0};
		pl = '{rapc_pkg::PRIO_EXT, rapc_pkg::PRIO_RPT, rapc_pkg::PRIO_NONE};
		gl = '{rapc_pkg::GRANT_EXT, rapc_pkg::GRANT_RPT, rapc_pkg::GRANT_EXT};
		rst = 1;
		wt(12);
		rst <= 0;
		wt(2);
		rd(rapc_pkg::ADDR_CTRL, '1, rapc_pkg::CTRL_RST, rapc_pkg::RESP_OKAY);
		rd(rapc_pkg::ADDR_PINS, '1, rapc_pkg::PINS_RST, rapc_pkg::RESP_OKAY);
		rd(8'h0C, '1, 32'h0, rapc_pkg::RESP_SLVERR);
		wr(8'h10, 32'hFFFF_FFFF, rapc_pkg::RESP_SLVERR);
		wr(rapc_pkg::ADDR_STAT, 32'hFFFF_FFFF, rapc_pkg::RESP_OKAY);
		wr(rapc_pkg::ADDR_PINS, 32'hFFFF_FFFF, rapc_pkg::RESP_OKAY);
		rd(rapc_pkg::ADDR_PINS, '1, rapc_pkg::PINS_MASK, rapc_pkg::RESP_OKAY);
		wr(rapc_pkg::ADDR_PINS, rapc_pkg::PINS_RST, rapc_pkg::RESP_OKAY);
		// Audio handling
		wr(rapc_pkg::ADDR_CTRL, cw(0, 1, 1, 0, 0, 0), rapc_pkg::RESP_OKAY);
		rd(rapc_pkg::ADDR_CTRL, '1, 32'h0000_0006, rapc_pkg::RESP_OKAY);
		chk1(band_filt_en, 1, "filter on");
		chk1(rx_deemph & tx_preemph, 1, "emphasis on");
		wr(rapc_pkg::ADDR_CTRL, cw(0, 1, 0, 0, 0, 0), rapc_pkg::RESP_OKAY);
		wt(2);
		chk1(tx_preemph, 0, "preemph off");
		chk1(rx_deemph, 1, "deemph kept");
		wr(rapc_pkg::ADDR_CTRL, cw(1, 1, 1, 0, 0, 0), rapc_pkg::RESP_OKAY);
		wt(2);
		chk1(band_filt_en, 0, "unfiltered");
		chk1(rx_deemph | tx_preemph, 0, "no emphasis");
		// Simultaneous requests under each priority
		for (int i = 0; i < 3; i++)
		begin
			wr(rapc_pkg::ADDR_CTRL, cw(0, 0, 0, 0, pl[i], rapc_pkg::MODE_ANA), rapc_pkg::RESP_OKAY);
			ktt <= 1;
			// Key-to-talk pin needs two sync edges to meet the repeat request
			wt(2);
			repeat_req <= 1;
			wt(6);
			gr(gl[i]);
			chk1(tx_from_input, gl[i] == rapc_pkg::GRANT_EXT, "tx source");
			chk1(seen[rapc_pkg::OUT_ANT], 1, "relay on");
			ktt <= 0;
			repeat_req <= 0;
			wt(6);
			chk1(seen[rapc_pkg::OUT_ANT], 0, "relay off");
		end
		// First come with no priority, grant held
		repeat_req <= 1;
		wt(6);
		ktt <= 1;
		wt(6);
		gr(rapc_pkg::GRANT_RPT);
		repeat_req <= 0;
		wt(6);
		gr(rapc_pkg::GRANT_EXT);
		ktt <= 0;
		// Repeat path disabled
		wr(rapc_pkg::ADDR_CTRL, cw(0, 0, 0, 1, rapc_pkg::PRIO_RPT, 0), rapc_pkg::RESP_OKAY);
		repeat_req <= 1;
		wt(6);
		chk1(tx_key, 0, "repeat blocked");
		ktt <= 1;
		wt(2);
		chk1(tx_key, 0, "sync delay");
		wt(4);
		chk1(tx_key, 1, "ext keys");
		ktt <= 0;
		// Knockdown
		wr(rapc_pkg::ADDR_CTRL, cw(0, 0, 0, 0, rapc_pkg::PRIO_RPT, 0), rapc_pkg::RESP_OKAY);
		kd <= 1;
		wt(6);
		chk1(tx_key, 0, "knockdown blocks");
		ktt <= 1;
		wt(6);
		chk1(tx_key & tx_from_input, 1, "knockdown ext");
		ktt <= 0;
		kd <= 0;
		wt(8);
		gr(rapc_pkg::GRANT_RPT);
		repeat_req <= 0;
		// Pin polarity and remapping
		wr(rapc_pkg::ADDR_PINS, 32'h0000_277F, rapc_pkg::RESP_OKAY);
		{ktt_pin, in_pol, out_pol} <= {2'h3, 4'hF, 3'h7};
		squelch_det <= 1;
		wt(6);
		chk1(acc_out[rapc_pkg::OUT_SQ], 0, "sq low active");
		chk1(acc_out[rapc_pkg::OUT_TONE], 1, "tone idle");
		squelch_det <= 0;
		tone_det <= 1;
		ktt <= 1;
		wt(6);
		chk1(acc_out[rapc_pkg::OUT_SQ], 1, "sq lost");
		chk1(acc_out[rapc_pkg::OUT_TONE], 0, "tone low active");
		chk1(tx_key, 1, "ktt on pin 3");
		{ktt, tone_det} <= '0;
		wr(rapc_pkg::ADDR_PINS, rapc_pkg::PINS_RST, rapc_pkg::RESP_OKAY);
		{ktt_pin, in_pol, out_pol} <= {2'h0, 4'h0, 3'h0};
		// Monitor
		mon <= 1;
		rf_carrier <= 1;
		wt(6);
		chk1(carrier_sq & rx_audio_en & spkr_unmute, 1, "monitor unmute");
		wr(rapc_pkg::ADDR_CTRL, cw(0, 0, 0, 1, rapc_pkg::PRIO_EXT, rapc_pkg::MODE_MIXED),
			rapc_pkg::RESP_OKAY);
		dig_activity <= 1;
		wt(4);
		chk1(spkr_unmute, 0, "digital muted");
		chk1(busy_tone, 1, "monitor busy tone");
		{mon, rf_carrier, dig_activity} <= '0;
		// Mixed mode arbitration
		dig_rx_req <= 1;
		ktt <= 1;
		wt(6);
		gr(rapc_pkg::GRANT_DIG);
		chk1(seen[rapc_pkg::OUT_ANT], 0, "no relay mixed");
		kd <= 1;
		wt(6);
		gr(rapc_pkg::GRANT_DIG);
		{dig_rx_req, ktt, kd} <= '0;
		wt(6);
		ktt <= 1;
		wt(6);
		dig_rx_req <= 1;
		chan_busy <= 1;
		wt(6);
		gr(rapc_pkg::GRANT_EXT);
		chk1(busy_tone, 1, "busy alert");
		{ktt, chan_busy} <= '0;
		wt(6);
		gr(rapc_pkg::GRANT_DIG);
		chk1(busy_tone, 0, "busy off");
		dig_rx_req <= 0;
		dig_tx_active <= 1;
		wt(4);
		chk32({30'h0, seen[1:0]}, 32'h3, "detects on call");
		dig_tx_active <= 0;
		station_identification <= 1;
		wt(4);
		chk32({30'h0, seen[1:0]}, 32'h3, "detects on id");
		station_identification <= 0;
		wt(4);
		chk32({30'h0, seen[1:0]}, 32'h0, "detects off");
		// Digital mode relay
		wr(rapc_pkg::ADDR_CTRL, cw(0, 0, 0, 0, 0, rapc_pkg::MODE_DIG), rapc_pkg::RESP_OKAY);
		ktt <= 1;
		wt(6);
		chk1(tx_key, 1, "digital ext");
		chk1(seen[rapc_pkg::OUT_ANT], 0, "no relay digital");
		ktt <= 0;
		wt(6);
		end_sim();
	end
endmodule
